/* File: cal_params.sv */
// Calibration parameter store with temperature compensation and RTC step correction.
// Assumes a plain register port from the serial host interface and one 200 MHz clock.
// Operation
// - config bit selects internal or host coefficients
// - nominal temperature and coefficients reset zero
// - first nominal write in internal mode auto-loads coefficients
// - later nominal writes keep nonzero coefficients
// - no nominal temperature, coefficients forced zero
// - zero nominal temperature disables compensation
// - step clock seconds, never retune oscillator
// - positive correction runs clock faster
// - correction sums offset/10, linear/100, quadratic/1000
// - gain parameter scales channel proportionally
// - Rogowski image gives defaults, feedthrough used
// - phase compensator spans 25Hz to 1100Hz
// - sample temperature once per interval
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module cal_params
    import cal_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Register port.
    input  wire cal_pkg::addr_t     addr,
    input  wire cal_pkg::word_t     wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output cal_pkg::word_t          rdata,
    // Temperature sensor and interval timing.
    input  wire cal_pkg::word_t     temp_raw_in,
    input  wire logic               interval_tick,
    input  wire logic               sec_tick,
    // Applied parameters to the metering path.
    output logic [6*24-1:0]         gain_out,
    output logic [3*24-1:0]         phadj_out,
    output logic [3*24-1:0]         feed_out,
    output logic signed [23:0]      lin_applied,
    output logic signed [23:0]      quad_applied,
    output logic signed [23:0]      delta_temp,
    // RTC corrections.
    output logic                    step_fwd,
    output logic                    step_back
);
    import cal_pkg::*;
    `include "cal_consts.svh"

    // Configuration: bit 0 internal mode, bits 2:1 image select.
    logic [2:0]  cfg_r, cfg_nxt;
    // Nominal temperature and the two reference drift coefficients.
    word_t       nom_r, nom_nxt;
    word_t       lin_r, lin_nxt;
    word_t       quad_r, quad_nxt;
    // Set once the host has written the nominal temperature.
    logic        nom_loaded_r, nom_loaded_nxt;
    // Clock correction coefficients.
    word_t       yc0_r, yc0_nxt, yc1_r, yc1_nxt, yc2_r, yc2_nxt;
    // Latest temperature sample.
    word_t       traw_r, traw_nxt;
    // Per-channel gains, per-phase phase and feedthrough parameters.
    word_t       gain_r  [6];
    word_t       gain_nxt[6];
    word_t       ph_r    [3];
    word_t       ph_nxt  [3];
    word_t       fd_r    [3];
    word_t       fd_nxt  [3];
    // Image mode flag; feedthrough only applies in Rogowski mode.
    logic        rogo;
    // Read data register.
    word_t       rdata_r, rdata_nxt;
    // Correction product in 0.001 ppm units.
    logic signed [31:0] corr_r, corr_nxt;

    assign rogo = (cfg_r[`CFG_IMAGE_LO +: 2] == `IMAGE_ROGOWSKI);

    // Write decode and coefficient side effects.
    always_comb begin
        cfg_nxt        = cfg_r;
        nom_nxt        = nom_r;
        lin_nxt        = lin_r;
        quad_nxt       = quad_r;
        nom_loaded_nxt = nom_loaded_r;
        yc0_nxt        = yc0_r;
        yc1_nxt        = yc1_r;
        yc2_nxt        = yc2_r;
        traw_nxt       = traw_r;
        gain_nxt       = gain_r;
        ph_nxt         = ph_r;
        fd_nxt         = fd_r;
        if (interval_tick) begin
            traw_nxt = temp_raw_in;
        end
        if (wr) begin
            case (addr)
                `REG_CONFIG: begin
                    cfg_nxt = wdata[2:0];
                end
                `REG_NOM_TEMP: begin
                    nom_nxt        = wdata;
                    nom_loaded_nxt = 1'b1;
                    // auto-load only in internal mode with zero coefficients
                    if (cfg_r[`CFG_INTERNAL_BIT] && lin_r == '0 && quad_r == '0) begin
                        lin_nxt  = `REF_LIN_DEFAULT;
                        quad_nxt = `REF_QUAD_DEFAULT;
                    end
                end
                `REG_LIN_COEF: begin
                    // writes ignored until the nominal value is loaded
                    // host mode merges its own correction here
                    if (nom_loaded_r) lin_nxt = wdata;
                end
                `REG_QUAD_COEF: begin
                    if (nom_loaded_r) quad_nxt = wdata;
                end
                `REG_CLK_OFFSET: yc0_nxt = wdata;
                `REG_CLK_LINEAR: yc1_nxt = wdata;
                `REG_CLK_QUAD:   yc2_nxt = wdata;
                default: begin
                    // gain stored as a linear multiplier
                    if (addr >= `REG_GAIN_BASE && addr < `REG_GAIN_BASE + 7'h06) begin
                        gain_nxt[3'(addr - `REG_GAIN_BASE)] = wdata;
                    end else if (addr >= `REG_PHADJ_BASE && addr < `REG_PHADJ_BASE + 7'h03) begin
                        ph_nxt[2'(addr - `REG_PHADJ_BASE)] = wdata;
                    end else if (addr >= `REG_FEED_BASE && addr < `REG_FEED_BASE + 7'h03) begin
                        fd_nxt[2'(addr - `REG_FEED_BASE)] = wdata;
                    end
                end
            endcase
        end
        // entering Rogowski mode loads nonzero phase defaults
        if (wr && addr == `REG_CONFIG && wdata[2:1] == `IMAGE_ROGOWSKI && !rogo) begin
            for (int i = 0; i < 3; i++) ph_nxt[i] = `PHADJ_ROGO_DEF;
        end
    end

    // Read mux: data stands in the cycle after the strobe.
    always_comb begin
        rdata_nxt = '0;
        if (rd) begin
            case (addr)
                `REG_CONFIG:     rdata_nxt = {21'h000000, cfg_r};
                `REG_NOM_TEMP:   rdata_nxt = nom_r;
                `REG_LIN_COEF:   rdata_nxt = lin_r;
                `REG_QUAD_COEF:  rdata_nxt = quad_r;
                `REG_CLK_OFFSET: rdata_nxt = yc0_r;
                `REG_CLK_LINEAR: rdata_nxt = yc1_r;
                `REG_CLK_QUAD:   rdata_nxt = yc2_r;
                `REG_TEMP_RAW:   rdata_nxt = traw_r;
                `REG_STATUS:     rdata_nxt = {22'h000000, rogo, nom_loaded_r};
                default: begin
                    if (addr >= `REG_GAIN_BASE && addr < `REG_GAIN_BASE + 7'h06) begin
                        rdata_nxt = gain_r[3'(addr - `REG_GAIN_BASE)];
                    end else if (addr >= `REG_PHADJ_BASE && addr < `REG_PHADJ_BASE + 7'h03) begin
                        rdata_nxt = ph_r[2'(addr - `REG_PHADJ_BASE)];
                    end else if (addr >= `REG_FEED_BASE && addr < `REG_FEED_BASE + 7'h03) begin
                        rdata_nxt = fd_r[2'(addr - `REG_FEED_BASE)];
                    end
                end
            endcase
        end
    end

    // Temperature difference from the nominal point.
    assign delta_temp = $signed(traw_r) - $signed(nom_r);

    // no compensation while nominal is zero
    // coefficients from auto-load or host writes
    assign lin_applied  = (nom_r == '0) ? 24'sh000000 : $signed(lin_r);
    assign quad_applied = (nom_r == '0) ? 24'sh000000 : $signed(quad_r);

    // correction in 0.001 ppm is 100*c0 + 10*c1*dT + c2*dT^2.
    always_comb begin
        logic signed [63:0] t0, t1, t2;
        t0 = 64'($signed(yc0_r)) * 64'sd100;
        t1 = 64'($signed(yc1_r)) * 64'sd10 * 64'(delta_temp);
        t2 = 64'($signed(yc2_r)) * 64'(delta_temp) * 64'(delta_temp);
        corr_nxt = 32'(t0 + t1 + t2);
    end

    // Register stage for all parameter state.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r        <= '0;
            nom_r        <= '0;
            lin_r        <= '0;
            quad_r       <= '0;
            nom_loaded_r <= 1'b0;
            yc0_r        <= '0;
            yc1_r        <= '0;
            yc2_r        <= '0;
            traw_r       <= '0;
            rdata_r      <= '0;
            corr_r       <= '0;
            for (int i = 0; i < 6; i++) gain_r[i] <= `GAIN_RESET;
            for (int i = 0; i < 3; i++) ph_r[i] <= '0;
            for (int i = 0; i < 3; i++) fd_r[i] <= '0;
        end else begin
            cfg_r        <= cfg_nxt;
            nom_r        <= nom_nxt;
            lin_r        <= lin_nxt;
            quad_r       <= quad_nxt;
            nom_loaded_r <= nom_loaded_nxt;
            yc0_r        <= yc0_nxt;
            yc1_r        <= yc1_nxt;
            yc2_r        <= yc2_nxt;
            traw_r       <= traw_nxt;
            rdata_r      <= rdata_nxt;
            corr_r       <= corr_nxt;
            gain_r       <= gain_nxt;
            ph_r         <= ph_nxt;
            fd_r         <= fd_nxt;
        end
    end

    assign rdata = rdata_r;

    // Flatten parameter banks onto output buses.
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_gain
            assign gain_out[g*24 +: 24] = gain_r[g];
        end
        for (g = 0; g < 3; g++) begin : g_phase
            // phase adjust feeds the wideband compensator
            assign phadj_out[g*24 +: 24] = ph_r[g];
            // feedthrough used only in Rogowski mode
            assign feed_out[g*24 +: 24]  = rogo ? fd_r[g] : 24'h000000;
        end
    endgenerate

    // Seconds stepper, the only submodule.
    rtc_stepper u_step (
        .clk       (clk),
        .arst_n    (arst_n),
        .corr_mppm (corr_r),
        .sec_tick  (sec_tick),
        .step_fwd  (step_fwd),
        .step_back (step_back)
    );

    // Auto-load sequence: internal mode, zero coefficients, nominal write.
    sequence s_autoload_req;
        wr && addr == `REG_NOM_TEMP && cfg_r[0] && lin_r == '0 && quad_r == '0;
    endsequence

    a_auto_load_fires: assert property (@(posedge clk) disable iff (!arst_n)
        s_autoload_req |=> (lin_r == `REF_LIN_DEFAULT && quad_r == `REF_QUAD_DEFAULT))
        else $error("coefficients not auto-loaded");
    a_coef_kept_later: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && addr == `REG_NOM_TEMP && (lin_r != '0 || quad_r != '0))
        |=> (lin_r == $past(lin_r) && quad_r == $past(quad_r)))
        else $error("coefficients changed on repeat nominal write");
    a_coef_held_zero: assert property (@(posedge clk) disable iff (!arst_n)
        !nom_loaded_r |-> (lin_r == '0 && quad_r == '0))
        else $error("coefficients nonzero before nominal load");
    a_no_comp_zero: assert property (@(posedge clk) disable iff (!arst_n)
        nom_r == '0 |-> (lin_applied == 0 && quad_applied == 0))
        else $error("compensation applied with zero nominal");
    a_host_mode_keep: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && addr == `REG_NOM_TEMP && !cfg_r[0]) |=> lin_r == $past(lin_r))
        else $error("host mode coefficient altered");
    a_temp_sample: assert property (@(posedge clk) disable iff (!arst_n)
        interval_tick |=> traw_r == $past(temp_raw_in))
        else $error("temperature sample missed");
    a_read_latency: assert property (@(posedge clk) disable iff (!arst_n)
        (rd && addr == `REG_NOM_TEMP) |=> rdata == $past(nom_r))
        else $error("read data wrong");
    a_feed_gated: assert property (@(posedge clk) disable iff (!arst_n)
        !rogo |-> feed_out == '0) else $error("feedthrough outside Rogowski");
    a_gain_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr && addr == `REG_GAIN_BASE) |=> gain_out[23:0] == $past(wdata))
        else $error("gain write lost");
endmodule : cal_params

/* File: cal_consts.svh */
// Constants for the calibration parameter block: register indices, field positions,
// reset values and timing counts.
// Assumes inclusion inside the bodies of the design modules.
`ifndef CAL_CONSTS_SVH
`define CAL_CONSTS_SVH

// Register addresses (7-bit register index space).
`define REG_CONFIG        7'h00
`define REG_NOM_TEMP      7'h01
`define REG_LIN_COEF      7'h02
`define REG_QUAD_COEF     7'h03
`define REG_CLK_OFFSET    7'h04
`define REG_CLK_LINEAR    7'h05
`define REG_CLK_QUAD      7'h06
`define REG_TEMP_RAW      7'h07
`define REG_STATUS        7'h08
`define REG_GAIN_BASE     7'h10
`define REG_PHADJ_BASE    7'h18
`define REG_FEED_BASE     7'h1c
// Config fields.
`define CFG_INTERNAL_BIT  0
`define CFG_IMAGE_LO      1
// Gain reset value, Rogowski phase default (phase resets to zero) and image code.
`define GAIN_RESET        24'h004000
`define PHADJ_ROGO_DEF    24'h000100
`define IMAGE_ROGOWSKI    2'h1
// Factory values of the internal reference drift coefficients.
`define REF_LIN_DEFAULT   24'hfffff6
`define REF_QUAD_DEFAULT  24'hffffe2
// One whole second of accumulated clock error, counted in 0.001 ppm-seconds.
`define ERR_FULL_SCALE    40'd1000000000
`endif

/* File: cal_pkg.sv */
// Types for the calibration parameter block.
// Assumes the constants header is available on the include path.
package cal_pkg;
    // Width of one calibration register.
    typedef logic [23:0] word_t;
    // Register index type.
    typedef logic [6:0]  addr_t;
    // Step sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FWD  = 3'b010,
        ST_BACK = 3'b100
    } step_state_t;
endpackage : cal_pkg

/* File: rtc_stepper.sv */
// Seconds-step corrector: accumulates frequency error and emits step pulses.
// Assumes a ppm correction value (scaled by 1000) updated from the main block.
module rtc_stepper
    import cal_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Correction in units of 0.001 ppm, signed.
    input  wire logic signed [31:0] corr_mppm,
    // Seconds tick from the time counter.
    input  wire logic               sec_tick,
    // Step requests.
    output logic                    step_fwd,
    output logic                    step_back
);
    import cal_pkg::*;
    `include "cal_consts.svh"

    // Step threshold held signed, so that a negative total compares as negative.
    localparam logic signed [47:0] FULL_SCALE = 48'(`ERR_FULL_SCALE);

    // Error accumulator in 0.001 ppm-seconds; one second equals 1e9 units.
    logic signed [47:0] acc_r, acc_nxt;
    step_state_t        st_r, st_nxt;

    // Next state: add error each second, then step when a whole second built up.
    always_comb begin
        acc_nxt = acc_r;
        st_nxt  = ST_IDLE;
        if (sec_tick) begin
            acc_nxt = acc_r + 48'(corr_mppm);
        end
        if (acc_r >= FULL_SCALE) begin
            acc_nxt = acc_nxt - FULL_SCALE;
            st_nxt  = ST_FWD;
        end else if (acc_r <= -FULL_SCALE) begin
            acc_nxt = acc_nxt + FULL_SCALE;
            st_nxt  = ST_BACK;
        end
    end

    // Register stage only.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= '0;
            st_r  <= ST_IDLE;
        end else begin
            acc_r <= acc_nxt;
            st_r  <= st_nxt;
        end
    end

    // Decoded one-cycle step pulses.
    always_comb begin
        case (st_r)
            ST_FWD:  begin step_fwd = 1'b1; step_back = 1'b0; end
            ST_BACK: begin step_fwd = 1'b0; step_back = 1'b1; end
            default: begin step_fwd = 1'b0; step_back = 1'b0; end
        endcase
    end

    // a forward and backward step never coincide.
    a_step_exclusive: assert property (@(posedge clk) disable iff (!arst_n)
        !(step_fwd && step_back)) else $error("both step directions active");
endmodule : rtc_stepper

/* File: host_model.sv */
// Host-side model that loads calibration parameters over the register port.
// Assumes one clock shared with the device and read data one cycle after the strobe.
module host_model
    import cal_pkg::*;
(
    // Clock.
    input  wire logic           clk,
    // Register port toward the device.
    output cal_pkg::addr_t      addr,
    output cal_pkg::word_t      wdata,
    output logic                wr,
    output logic                rd,
    input  wire cal_pkg::word_t rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus idles with both strobes low.
    initial begin
        addr  = 7'h00;
        wdata = 24'h000000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One write cycle; data are inverted on release so a stale value never looks valid.
    task automatic put(input addr_t a, input word_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : put

    // One read cycle; the answer is taken in the cycle after the strobe.
    task automatic get(input addr_t a, output word_t d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : get

    task automatic load(input logic internal);
        word_t raw;
        put(7'h00, {23'h000000, internal});
        get(7'h07, raw);
        put(7'h01, raw);
    endtask : load

    task automatic merge(input addr_t a, input word_t extra);
        word_t v;
        get(a, v);
        put(a, v + extra);
    endtask : merge
endmodule : host_model

/* File: tb_top.sv */
// Self-checking bench for the calibration parameter store.
// Assumes the host model drives the register port and the bench drives sensor and ticks.
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cal_pkg::*;

    // One table row: address, written value, value expected back.
    typedef struct {addr_t a; word_t d; word_t e;} row_t;
    logic                  clk;
    logic                  arst_n;
    addr_t                 addr;
    word_t                 wdata;
    logic                  wr;
    logic                  rd;
    word_t                 rdata;
    word_t                 temp_raw_in;
    logic                  interval_tick;
    logic                  sec_tick;
    logic [6*24-1:0]       gain_out;
    logic [3*24-1:0]       phadj_out;
    logic [3*24-1:0]       feed_out;
    logic signed [23:0]    lin_applied;
    logic signed [23:0]    quad_applied;
    logic signed [23:0]    delta_temp;
    logic                  step_fwd;
    logic                  step_back;
    int                    mismatches = 0;
    int                    compares = 0;
    int                    nf;
    int                    nb;
    word_t                 v;
    // Writable places, a read-only one and an unmapped one.
    row_t rows [13] = '{
        '{7'h10, 24'h004147, 24'h004147}, '{7'h11, 24'h003f00, 24'h003f00},
        '{7'h12, 24'h000001, 24'h000001}, '{7'h13, 24'hffffff, 24'hffffff},
        '{7'h14, 24'h7fffff, 24'h7fffff}, '{7'h15, 24'h123456, 24'h123456},
        '{7'h18, 24'h000abc, 24'h000abc}, '{7'h1a, 24'hfff000, 24'hfff000},
        '{7'h1c, 24'h000055, 24'h000055}, '{7'h05, 24'hfffffe, 24'hfffffe},
        '{7'h06, 24'h000003, 24'h000003}, '{7'h7f, 24'habcdef, 24'h000000},
        '{7'h07, 24'h111111, 24'h000000}};

    cal_params cal_params_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .temp_raw_in(temp_raw_in),
        .interval_tick(interval_tick), .sec_tick(sec_tick), .gain_out(gain_out),
        .phadj_out(phadj_out), .feed_out(feed_out), .lin_applied(lin_applied),
        .quad_applied(quad_applied), .delta_temp(delta_temp), .step_fwd(step_fwd),
        .step_back(step_back));
    host_model host_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Step pulses are counted on every edge so none slips between ticks.
    always @(posedge clk) begin
        if (step_fwd === 1'b1) nf++;
        if (step_back === 1'b1) nb++;
    end

    // Hangs are cut short well inside the cycle budget.
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize();
    end

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    // Holds reset for ten cycles; usable again in mid-run.
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
    endtask : do_reset

    // Lets a written value reach the registered outputs.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // One accumulation-interval pulse latching the sensor reading.
    task automatic sample(input word_t t);
        @(posedge clk);
        temp_raw_in   <= t;
        interval_tick <= 1'b1;
        @(posedge clk);
        interval_tick <= 1'b0;
    endtask : sample

    // Issues n seconds ticks, five cycles apart; the caller clears the step counts.
    task automatic ticks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sec_tick <= 1'b1;
            @(posedge clk);
            sec_tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : ticks

    initial begin
        arst_n        = 1'b0;
        temp_raw_in   = 24'h000000;
        interval_tick = 1'b0;
        sec_tick      = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            host_model_inst.get(k[6:0], v);
            `CHK("reset value", 24'h000000, v)
        end
        for (int k = 0; k < 6; k++) `CHK("gain reset", 24'h004000, gain_out[24*k +: 24])
        host_model_inst.put(7'h02, 24'h000123);
        host_model_inst.get(7'h02, v);
        `CHK("coef before nominal", 24'h000000, v)
        for (int i = 0; i < 13; i++) begin
            host_model_inst.put(rows[i].a, rows[i].d);
            host_model_inst.get(rows[i].a, v);
            `CHK("readback", rows[i].e, v)
            if (rows[i].a >= 7'h10 && rows[i].a <= 7'h15)
                `CHK("gain_out", rows[i].d, gain_out[24*(rows[i].a-16) +: 24])
        end
        `CHK("feed idle", 72'h0, feed_out)
        sample(24'h000321);
        host_model_inst.load(1'b1);
        host_model_inst.get(7'h07, v);
        `CHK("temp sample", 24'h000321, v)
        host_model_inst.get(7'h02, v);
        `CHK("lin auto", 24'hfffff6, v)
        host_model_inst.get(7'h03, v);
        `CHK("quad auto", 24'hffffe2, v)
        sample(24'h000325);
        settle();
        `CHK("lin applied", 24'hfffff6, lin_applied)
        `CHK("quad applied", 24'hffffe2, quad_applied)
        `CHK("delta temp", 24'h000004, delta_temp)
        host_model_inst.put(7'h01, 24'h000300);
        host_model_inst.get(7'h02, v);
        `CHK("lin kept", 24'hfffff6, v)
        host_model_inst.put(7'h00, 24'h000003);
        settle();
        for (int k = 0; k < 3; k++) `CHK("phadj default", 24'h000100, phadj_out[24*k +: 24])
        `CHK("feed used", 24'h000055, feed_out[23:0])
        host_model_inst.get(7'h08, v);
        `CHK("status flags", 24'h000003, v)
        host_model_inst.put(7'h01, 24'h000000);
        settle();
        `CHK("lin disabled", 24'h000000, lin_applied)
        `CHK("quad disabled", 24'h000000, quad_applied)
        // host mode, no auto-load, merged write
        do_reset();
        sample(24'h000200);
        host_model_inst.load(1'b0);
        host_model_inst.get(7'h02, v);
        `CHK("host mode no load", 24'h000000, v)
        host_model_inst.merge(7'h02, 24'h000007);
        host_model_inst.get(7'h02, v);
        `CHK("host merge", 24'h000007, v)
        // full positive offset steps forward on the second tick
        do_reset();
        host_model_inst.put(7'h04, 24'h7fffff);
        nf = 0;
        nb = 0;
        ticks(1);
        `CHK("no early step", 0, nf)
        ticks(1);
        `CHK("fwd steps", 1, nf)
        `CHK("no back step", 0, nb)
        do_reset();
        host_model_inst.put(7'h04, 24'h800001);
        nf = 0;
        nb = 0;
        ticks(2);
        `CHK("back steps", 1, nb)
        `CHK("no fwd step", 0, nf)
        summarize();
    end
endmodule : tb_top
